// ===== inc/pfc_pkg.sv
// pfc_pkg: register map, field positions, reset values and sizes of the
// parallel channel fifo control block.
// assumes an 8-bit register port with byte addresses.
package pfc_pkg;
    // register offsets
    localparam logic [7:0] PFC_OFF_FIFO_CTRL = 8'h31;
    localparam logic [7:0] PFC_OFF_HOLD1 = 8'h35;
    localparam logic [7:0] PFC_OFF_HOLD2 = 8'h36;
    localparam logic [7:0] PFC_OFF_LEVEL = 8'h3A;
    localparam logic [7:0] PFC_OFF_THRESH = 8'h3B;
    localparam logic [7:0] PFC_OFF_DMA_BUFFER_REG = 8'h3C;
    localparam logic [7:0] PFC_OFF_FSTAT = 8'h3D;
    localparam logic [7:0] PFC_OFF_ERRSTAT = 8'h3E;
    localparam logic [7:0] PFC_OFF_IRQSTAT = 8'h40;
    localparam logic [7:0] PFC_OFF_SOFT_RST = 8'h6C;
    // fifo_control fields
    localparam int PFC_CTRL_FLUSH_BIT = 7;
    localparam int PFC_CTRL_DMA_EN_BIT = 6;
    localparam int PFC_CTRL_DIR_BIT = 5;
    localparam int PFC_CTRL_IRQ_EN_BIT = 4;
    localparam int PFC_CTRL_RLE_BIT = 3;
    localparam int PFC_CTRL_TAG_BIT = 2;
    localparam int PFC_CTRL_ERR_EN_BIT = 1;
    localparam int PFC_CTRL_BUFWE_BIT = 0;
    // channel_soft_reset_control field
    localparam int PFC_SOFT_RST_BIT = 0;
    // fifo_status_reg fields
    localparam int PFC_FS_FULL_BIT = 7;
    localparam int PFC_FS_EMPTY_BIT = 6;
    localparam int PFC_FS_HRTAG_BIT = 4;
    localparam int PFC_FS_HRDATA_BIT = 3;
    localparam int PFC_FS_ERROR_STATUS_REG_BIT = 0;
    // irq status fields: service flag, vector, pending sources
    localparam int PFC_IRQ_SVC_BIT = 7;
    localparam int PFC_IRQ_VEC_LSB = 3;
    // reset values
    localparam logic [7:0] PFC_CTRL_RST = 8'h00;
    localparam logic [7:0] PFC_SOFT_RST_RST = 8'h00;
    localparam logic [7:0] PFC_THRESH_RST = 8'h20;
    // fifo size and level after flush
    localparam int PFC_FIFO_DEPTH = 64;
    localparam logic [7:0] PFC_LEVEL_RX_INIT = 8'h00;
    localparam logic [7:0] PFC_LEVEL_TX_INIT = 8'h40;
    // interrupt vector codes
    typedef enum logic [1:0] {
        PFC_VEC_NONE = 2'b00,
        PFC_VEC_CHAN = 2'b01,
        PFC_VEC_ERR = 2'b10,
        PFC_VEC_FIFO = 2'b11
    } pfc_vec_e;
endpackage : pfc_pkg

// ===== rtl/pfc_fifo.sv
// pfc_fifo: byte fifo with tag bit, synchronous flush and occupancy count.
// assumes push is never given when full nor pop when empty.
module pfc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic pop_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic [$clog2(DEPTH):0] count_o,
    output logic [$clog2(DEPTH):0] count_next_o,
    output logic full_o,
    output logic empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic do_push;
    logic do_pop;

    // guard against misuse so the count can never wrap
    assign do_push = push_i && (count_q != (AW+1)'(DEPTH));
    assign do_pop = pop_i && (count_q != '0);
    assign count_d = flush_i ? '0 : count_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    assign rdata_o = mem_q[rptr_q];
    assign count_o = count_q;
    assign count_next_o = count_d;
    assign full_o = (count_q == (AW+1)'(DEPTH));
    assign empty_o = (count_q == '0);

    // storage carries no reset; only pointers and count matter
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wptr_q] <= wdata_i;
        end
    end

    // pointers and count return to zero on reset or flush
    always_ff @(posedge clk_i) begin
        if (rst_i || flush_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_q + AW'(do_push);
            rptr_q <= rptr_q + AW'(do_pop);
        end
        count_q <= rst_i ? '0 : count_d;
    end
endmodule : pfc_fifo

// ===== rtl/pfc_top.sv
// pfc_top: control of the parallel channel fifo, its two-stage holding
// pipeline, the dma buffer, dma request and service request.
// assumes a single-cycle register port, a one-cycle dma acknowledge and a
// parallel port engine with valid/ready byte streams on the far side.
// Notes on behaviour
// RULE1 - channel soft reset bit holds the channel as if power-on reset.
// RULE2 - host must clear the soft reset bit; it never clears itself.
// RULE3 - soft reset touches only channel logic, not the reset register or bus.
// RULE4 - host writes zero to bits 7:1 of the soft reset register.
// RULE5 - fifo_control clears to zero on pin reset or soft reset.
// RULE6 - flush empties pipeline and fifo; host sets it with direction.
// RULE7 - with dma enabled, fifo level is compared with threshold continuously.
// RULE8 - receive: request dma while level at or above threshold, whole words.
// RULE9 - transmit: request dma while fifo data at or below threshold.
// RULE10 - direction one is transmit to fifo, zero is receive from fifo.
// RULE11 - host keeps the direction value in later control writes.
// RULE12 - master enable gates every interrupt; clear means no request.
// RULE13 - toggling master enable clears pending, service, vector and re-evaluates.
// RULE14 - host reads and rechecks status at start and end of service.
// RULE15 - rle in transmit keeps both holding stages full.
// RULE16 - host clears rle, dma enable and buffer write enable to drain.
// RULE17 - next byte written to stage one is tagged; tag bit then clears.
// RULE18 - error enable lets a data error raise an interrupt under master enable.
// RULE19 - buffer write enable allows host writes to the dma buffer, then drained.
// RULE20 - data flows stage one, stage two, then fifo or dma buffer.
// RULE21 - flush sets level to zero data in receive, sixty-four free in transmit.
//
// The implementer's own choice: the strobed register port.
module pfc_top import pfc_pkg::*; #(
    parameter int DEPTH = PFC_FIFO_DEPTH
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic dma_ack_i,
    input wire logic [15:0] dma_wdata_i,
    output logic [15:0] dma_rdata_o,
    output logic dma_request_n_o,
    input wire logic pp_rx_valid_i,
    input wire logic [7:0] pp_rx_data_i,
    input wire logic pp_rx_tag_i,
    input wire logic pp_rx_err_i,
    output logic pp_rx_ready_o,
    output logic pp_tx_valid_o,
    output logic [7:0] pp_tx_data_o,
    output logic pp_tx_tag_o,
    input wire logic pp_tx_ready_i,
    input wire logic chan_irq_i,
    output logic chan_reset_o,
    output logic service_request_n_o
);
    localparam int CW = $clog2(DEPTH) + 1;
    logic soft_rst_q, chan_rst;
    logic [7:0] ctrl_q, ctrl_d, thr_q, error_status_reg_q, rdata_q, rd_mux, level, fstat, irqstat;
    logic [7:0] s1_q, s2_q;
    logic s1_vld_q, s1_tag_q, s2_vld_q, s2_tag_q;
    logic [15:0] buf_q;
    logic [1:0] buf_cnt_q;
    logic tx_vld_q, tx_tag_q, rx_rdy_q, dreq_n_q, svc_n_q, service_q;
    logic [7:0] tx_data_q;
    logic [2:0] pending_q, src;
    pfc_vec_e vec_q, vec_d;
    logic [8:0] fifo_wdata, fifo_rdata;
    logic [CW-1:0] fifo_cnt, fifo_cnt_next;
    logic fifo_full, fifo_empty, fifo_push, fifo_pop;

    // register decode
    logic wr_ctrl, wr_thr, wr_hold1, wr_buf, wr_err, wr_soft;
    logic rd_hold1, rd_hold2, rd_buf, rd_irq;
    assign wr_ctrl = reg_wr_i && (reg_addr_i == PFC_OFF_FIFO_CTRL);
    assign wr_thr = reg_wr_i && (reg_addr_i == PFC_OFF_THRESH);
    assign wr_hold1 = reg_wr_i && (reg_addr_i == PFC_OFF_HOLD1);
    assign wr_buf = reg_wr_i && (reg_addr_i == PFC_OFF_DMA_BUFFER_REG);
    assign wr_err = reg_wr_i && (reg_addr_i == PFC_OFF_ERRSTAT);
    assign wr_soft = reg_wr_i && (reg_addr_i == PFC_OFF_SOFT_RST);
    assign rd_hold1 = reg_rd_i && (reg_addr_i == PFC_OFF_HOLD1);
    assign rd_hold2 = reg_rd_i && (reg_addr_i == PFC_OFF_HOLD2);
    assign rd_buf = reg_rd_i && (reg_addr_i == PFC_OFF_DMA_BUFFER_REG);
    assign rd_irq = reg_rd_i && (reg_addr_i == PFC_OFF_IRQSTAT);

    // control field views
    logic flush, dma_en, tx, irq_en, rle, tag_next, err_en, bufwe, irq_toggle;
    assign flush = wr_ctrl && reg_wdata_i[PFC_CTRL_FLUSH_BIT]; // RULE6
    assign dma_en = ctrl_q[PFC_CTRL_DMA_EN_BIT];
    assign tx = ctrl_q[PFC_CTRL_DIR_BIT]; // RULE10
    assign irq_en = ctrl_q[PFC_CTRL_IRQ_EN_BIT];
    assign rle = ctrl_q[PFC_CTRL_RLE_BIT];
    assign tag_next = ctrl_q[PFC_CTRL_TAG_BIT];
    assign err_en = ctrl_q[PFC_CTRL_ERR_EN_BIT];
    assign bufwe = ctrl_q[PFC_CTRL_BUFWE_BIT];
    assign irq_toggle = wr_ctrl && (reg_wdata_i[PFC_CTRL_IRQ_EN_BIT] != irq_en);
    assign chan_rst = rst_i || soft_rst_q; // RULE1

    // soft reset bit: only the pin resets it and only a host write clears it, so the bus and this register
    // stay usable while the channel is held; upper bits are not stored
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            soft_rst_q <= PFC_SOFT_RST_RST[PFC_SOFT_RST_BIT]; // RULE3
        end else if (wr_soft) begin
            soft_rst_q <= reg_wdata_i[PFC_SOFT_RST_BIT]; // RULE1
        end
    end

    // flush is a pulse and reads back zero; tag bit drops on the tagged write
    logic hold1_wr_ok;
    assign hold1_wr_ok = wr_hold1 && !s1_vld_q;
    assign ctrl_d = wr_ctrl ? {1'b0, reg_wdata_i[6:0]}
                  : (hold1_wr_ok ? (ctrl_q & ~(8'h01 << PFC_CTRL_TAG_BIT)) : ctrl_q); // RULE17

    // control register cleared and threshold loaded with 20h by either reset
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst) begin
            ctrl_q <= PFC_CTRL_RST; // RULE5
            thr_q <= PFC_THRESH_RST;
        end else begin
            ctrl_q <= ctrl_d;
            thr_q <= wr_thr ? reg_wdata_i : thr_q;
        end
    end

    // pipeline moves; one move per stage per cycle keeps the priorities plain,
    // at the cost of one byte every two cycles through the stages
    logic buf_host_wr, tx_ack, rx_ack, buf_to_s1, s1_to_s2, tx_push, fifo_to_s1;
    logic s2_to_buf, buf_rd_pop, tx_out_load, rx_push;
    assign tx_ack = dma_ack_i && tx && (buf_cnt_q == 2'h0);
    assign rx_ack = dma_ack_i && !tx && (buf_cnt_q == 2'h2);
    assign buf_host_wr = wr_buf && bufwe && tx && (buf_cnt_q != 2'h2) && !tx_ack; // RULE19
    assign buf_to_s1 = tx && (buf_cnt_q != 2'h0) && !s1_vld_q && !wr_hold1 && !buf_host_wr; // RULE20
    assign s1_to_s2 = s1_vld_q && !s2_vld_q && !rd_hold1; // RULE20
    // with rle the second stage only advances when a fresh byte waits behind
    assign tx_push = tx && s2_vld_q && !fifo_full && !rd_hold2
                     && (!rle || (s1_vld_q && (buf_cnt_q != 2'h0))); // RULE15
    assign fifo_to_s1 = !tx && !fifo_empty && !s1_vld_q && !wr_hold1; // RULE20
    assign buf_rd_pop = rd_buf && !tx && (buf_cnt_q != 2'h0) && !rx_ack;
    // a received tag stops dma flow until the host reads it out
    assign s2_to_buf = !tx && s2_vld_q && !s2_tag_q && (buf_cnt_q != 2'h2)
                       && !rx_ack && !buf_rd_pop && !rd_hold2;
    assign tx_out_load = tx && !fifo_empty && (!tx_vld_q || pp_tx_ready_i);
    assign rx_push = !tx && pp_rx_valid_i && rx_rdy_q;
    assign fifo_push = tx ? tx_push : rx_push;
    assign fifo_pop = tx ? tx_out_load : fifo_to_s1;
    assign fifo_wdata = tx ? {s2_tag_q, s2_q} : {pp_rx_tag_i, pp_rx_data_i};

    // holding stage one
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst || flush) begin
            s1_vld_q <= 1'b0; // RULE6
            s1_tag_q <= 1'b0;
            s1_q <= 8'h00;
        end else if (hold1_wr_ok) begin
            {s1_vld_q, s1_tag_q, s1_q} <= {1'b1, tag_next, reg_wdata_i}; // RULE17
        end else if (buf_to_s1) begin
            {s1_vld_q, s1_tag_q, s1_q} <= {1'b1, 1'b0, buf_q[7:0]};
        end else if (fifo_to_s1) begin
            {s1_vld_q, s1_tag_q, s1_q} <= {1'b1, fifo_rdata};
        end else if (s1_to_s2 || rd_hold1) begin
            s1_vld_q <= 1'b0;
        end
    end

    // holding stage two
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst || flush) begin
            {s2_vld_q, s2_tag_q, s2_q} <= {1'b0, 1'b0, 8'h00}; // RULE6
        end else if (s1_to_s2) begin
            {s2_vld_q, s2_tag_q, s2_q} <= {1'b1, s1_tag_q, s1_q};
        end else if (tx_push || s2_to_buf || rd_hold2) begin
            s2_vld_q <= 1'b0;
        end
    end

    // dma buffer: one 16-bit word, low byte first on the parallel side
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst || flush) begin
            buf_q <= 16'h0000;
            buf_cnt_q <= 2'h0;
        end else if (tx_ack) begin
            buf_q <= dma_wdata_i;
            buf_cnt_q <= 2'h2;
        end else if (buf_host_wr) begin
            buf_q <= (buf_cnt_q == 2'h0) ? {8'h00, reg_wdata_i} : {reg_wdata_i, buf_q[7:0]};
            buf_cnt_q <= buf_cnt_q + 2'h1;
        end else if (buf_to_s1 || buf_rd_pop) begin
            buf_q <= {8'h00, buf_q[15:8]};
            buf_cnt_q <= buf_cnt_q - 2'h1;
        end else if (rx_ack) begin
            buf_cnt_q <= 2'h0;
        end else if (s2_to_buf) begin
            buf_q <= (buf_cnt_q == 2'h0) ? {8'h00, s2_q} : {s2_q, buf_q[7:0]};
            buf_cnt_q <= buf_cnt_q + 2'h1;
        end
    end

    pfc_fifo #(
        .WIDTH(9),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(sys_clk_i),
        .rst_i(chan_rst),
        .flush_i(flush),
        .push_i(fifo_push),
        .wdata_i(fifo_wdata),
        .pop_i(fifo_pop),
        .rdata_o(fifo_rdata),
        .count_o(fifo_cnt),
        .count_next_o(fifo_cnt_next),
        .full_o(fifo_full),
        .empty_o(fifo_empty)
    );

    // level reads data held in receive, free space in transmit
    assign level = tx ? 8'(DEPTH - int'(fifo_cnt)) : 8'(fifo_cnt); // RULE21

    // dma request: whole words only, dropped at once on acknowledge
    logic rx_req, tx_req;
    assign rx_req = dma_en && !tx && (level >= thr_q) && (buf_cnt_q == 2'h2); // RULE7 RULE8
    assign tx_req = dma_en && tx && (8'(fifo_cnt) <= thr_q) && (buf_cnt_q == 2'h0); // RULE7 RULE9

    // port-facing stream registers and request outputs
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst) begin
            tx_vld_q <= 1'b0;
            tx_tag_q <= 1'b0;
            tx_data_q <= 8'h00;
            rx_rdy_q <= 1'b0;
            dreq_n_q <= 1'b1;
        end else begin
            if (flush) begin
                tx_vld_q <= 1'b0;
            end else if (tx_out_load) begin
                {tx_vld_q, tx_tag_q, tx_data_q} <= {1'b1, fifo_rdata};
            end else if (pp_tx_ready_i) begin
                tx_vld_q <= 1'b0;
            end
            // ready looks at next count so the fifo cannot overflow
            rx_rdy_q <= !ctrl_d[PFC_CTRL_DIR_BIT] && (fifo_cnt_next < CW'(DEPTH)); // RULE10
            dreq_n_q <= !((rx_req || tx_req) && !dma_ack_i && !flush);
        end
    end

    // data error flag: set wins over a write-one clear
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst) begin
            error_status_reg_q <= 8'h00;
        end else begin
            error_status_reg_q[0] <= pp_rx_err_i || (error_status_reg_q[0] && !(wr_err && reg_wdata_i[0]));
        end
    end

    // interrupt sources: channel, enabled data error, received tag
    assign src = {!tx && s2_vld_q && s2_tag_q, err_en && (error_status_reg_q != 8'h00), chan_irq_i}; // RULE18
    assign vec_d = pending_q[0] ? PFC_VEC_CHAN : pending_q[1] ? PFC_VEC_ERR
                 : pending_q[2] ? PFC_VEC_FIFO : PFC_VEC_NONE;

    // pending tracks live sources until serviced; a toggle of the master
    // enable wipes the service state and the next cycle re-evaluates
    always_ff @(posedge sys_clk_i) begin
        if (chan_rst || irq_toggle) begin
            pending_q <= 3'h0; // RULE13
            service_q <= 1'b0;
            vec_q <= PFC_VEC_NONE;
        end else begin
            pending_q <= (irq_en && !service_q) ? src : (irq_en ? pending_q : 3'h0); // RULE12
            if (rd_irq && (pending_q != 3'h0) && !service_q) begin
                service_q <= 1'b1;
                vec_q <= vec_d;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        svc_n_q <= chan_rst ? 1'b1 : !(irq_en && (pending_q != 3'h0) && !service_q); // RULE12
    end

    // status views
    always_comb begin
        fstat = 8'h00;
        fstat[PFC_FS_FULL_BIT] = fifo_full;
        fstat[PFC_FS_EMPTY_BIT] = fifo_empty;
        fstat[PFC_FS_HRTAG_BIT] = (s1_vld_q && s1_tag_q) || (s2_vld_q && s2_tag_q);
        fstat[PFC_FS_HRDATA_BIT] = s1_vld_q || s2_vld_q;
        fstat[PFC_FS_ERROR_STATUS_REG_BIT] = (error_status_reg_q != 8'h00);
        irqstat = 8'h00;
        irqstat[PFC_IRQ_SVC_BIT] = service_q;
        irqstat[PFC_IRQ_VEC_LSB +: 2] = vec_q;
        irqstat[2:0] = pending_q;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        unique case (reg_addr_i)
            PFC_OFF_FIFO_CTRL: rd_mux = ctrl_q;
            PFC_OFF_SOFT_RST: rd_mux = {7'h00, soft_rst_q};
            PFC_OFF_HOLD1: rd_mux = s1_q;
            PFC_OFF_HOLD2: rd_mux = s2_q;
            PFC_OFF_LEVEL: rd_mux = level;
            PFC_OFF_THRESH: rd_mux = thr_q;
            PFC_OFF_DMA_BUFFER_REG: rd_mux = buf_q[7:0];
            PFC_OFF_FSTAT: rd_mux = fstat;
            PFC_OFF_ERRSTAT: rd_mux = error_status_reg_q;
            PFC_OFF_IRQSTAT: rd_mux = irqstat;
            default: rd_mux = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        rdata_q <= (rst_i || !reg_rd_i) ? 8'h00 : rd_mux; // RULE3
    end

    assign reg_rdata_o = rdata_q;
    assign dma_rdata_o = buf_q;
    assign dma_request_n_o = dreq_n_q;
    assign pp_rx_ready_o = rx_rdy_q;
    assign pp_tx_valid_o = tx_vld_q;
    assign pp_tx_data_o = tx_data_q;
    assign pp_tx_tag_o = tx_tag_q;
    assign chan_reset_o = soft_rst_q;
    assign service_request_n_o = svc_n_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (chan_rst);

    a_soft_rst_holds: assert property (disable iff (rst_i) soft_rst_q |=> ctrl_q == PFC_CTRL_RST && !s1_vld_q
        && buf_cnt_q == 2'h0 && dma_request_n_o) else $error("soft reset did not hold channel"); // RULE1 RULE5
    a_soft_rst_bus: assert property (disable iff (rst_i) soft_rst_q && reg_rd_i && reg_addr_i == PFC_OFF_SOFT_RST
        |=> reg_rdata_o[0]) else $error("soft reset disturbed register read"); // RULE3
    a_flush_empties: assert property (flush |=> !s1_vld_q && !s2_vld_q && buf_cnt_q == 2'h0
        && level == ($past(reg_wdata_i[PFC_CTRL_DIR_BIT]) ? PFC_LEVEL_TX_INIT : PFC_LEVEL_RX_INIT))
        else $error("flush left data or wrong level"); // RULE6 RULE21
    a_req_needs_en: assert property (!dma_en |=> dma_request_n_o) else $error("dma request without enable"); // RULE7
    a_rx_req_thresh: assert property (!dma_request_n_o && !tx |-> $past(!tx && level >= thr_q))
        else $error("receive request below threshold"); // RULE8
    a_tx_req_thresh: assert property (!dma_request_n_o && tx |-> $past(tx && 8'(fifo_cnt) <= thr_q))
        else $error("transmit request above threshold"); // RULE9
    a_dir_rx_ready: assert property (tx |-> !pp_rx_ready_o) else $error("receive ready in transmit"); // RULE10
    a_irq_gated: assert property (!irq_en |=> service_request_n_o) else $error("interrupt without enable"); // RULE12
    a_toggle_clears: assert property (irq_toggle |=> pending_q == 3'h0 && !service_q && vec_q == PFC_VEC_NONE)
        else $error("toggle did not clear service state"); // RULE13
    a_rle_keeps_full: assert property (tx && rle && s1_vld_q && s2_vld_q && buf_cnt_q == 2'h0 && !reg_rd_i
        && !wr_ctrl |=> s1_vld_q && s2_vld_q) else $error("rle let holding stages drain"); // RULE15
    a_tag_write: assert property (hold1_wr_ok |=> s1_vld_q && s1_tag_q == $past(tag_next) && !tag_next)
        else $error("tagged write mishandled"); // RULE17
    a_err_irq: assert property (irq_en && err_en && error_status_reg_q != 8'h00 && !service_q && !wr_ctrl
        |=> pending_q[1]) else $error("data error not pending"); // RULE18
    a_host_buf_wr: assert property (buf_host_wr && buf_cnt_q == 2'h0 |=> buf_cnt_q == 2'h1)
        else $error("host buffer write lost"); // RULE19
    a_pipe_order: assert property ($rose(s2_vld_q) |-> $past(s1_vld_q)) else $error("stage two skipped stage one"); // RULE20

    c_flush_tx: cover property (flush && reg_wdata_i[PFC_CTRL_DIR_BIT]);
    c_tx_request: cover property (tx && $fell(dma_request_n_o));
    c_rx_request: cover property (!tx && $fell(dma_request_n_o));
    c_service: cover property ($fell(service_request_n_o) ##[1:20] rd_irq);
endmodule : pfc_top

// ===== testbench/pfc_port_model.sv
// pfc_port_model: behavioural parallel port engine on the fifo's far side.
// assumes the valid/ready byte streams of pfc_top and one clock.
module pfc_port_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic [7:0] rx_n_i,
    input wire logic err_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_tag_i,
    input wire logic rx_ready_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_err_o
);
    logic [7:0] sent_q;
    logic [8:0] log_q [16];
    logic [3:0] log_cnt_q;
    // rx bytes count up from A1; once idle the line shows the inverted last byte
    assign rx_valid_o = sent_q < rx_n_i;
    assign rx_data_o = rx_valid_o ? 8'hA1 + sent_q : ~(8'hA0 + sent_q);
    // sink stalls every other cycle when slow, so the block must hold its byte
    always_ff @(posedge clk_i) begin
        rx_err_o <= err_i;
        if (rst_i) begin
            sent_q <= 8'h00;
            log_cnt_q <= 4'h0;
            tx_ready_o <= 1'b0;
        end else begin
            sent_q <= sent_q + 8'(rx_valid_o && rx_ready_i);
            tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
            if (tx_valid_i && tx_ready_o) begin
                log_q[log_cnt_q] <= {tx_tag_i, tx_data_i};
                log_cnt_q <= log_cnt_q + 4'h1;
            end
        end
    end
endmodule : pfc_port_model

// ===== testbench/tb_parallel_fifo_control.sv
// tb_parallel_fifo_control: self-checking bench for pfc_top.
// assumes pfc_port_model on the port side; the bench acts as host and dma.
module tb_parallel_fifo_control import pfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ack = 1'b0, slow = 1'b0, err = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rx_n = 8'h00, rdata, rx_data, tx_data, got;
    logic [15:0] dwdata = 16'h0000, drdata;
    logic dreq_n, rx_valid, rx_err, rx_ready, tx_valid, tx_ready, chan_rst, svc_n, tx_tag;
    int num_errors = 0, num_checks = 0;
    // rows: {we, write addr, write data, read addr, expected}
    logic [39:0] rows [6] = '{40'h0131A03A40, 40'h0131803A00, 40'h0131123112, 40'h013B023B02,
        40'h0110551000, 40'h0000006C00};
    logic [8:0] txq [7] = '{9'h034, 9'h012, 9'h055, 9'h066, 9'h077, 9'h088, 9'h199};
    always #2.5 clk = ~clk;
    pfc_top i_dut (.sys_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .dma_ack_i(ack), .dma_wdata_i(dwdata), .dma_rdata_o(drdata),
        .dma_request_n_o(dreq_n), .pp_rx_valid_i(rx_valid), .pp_rx_data_i(rx_data), .pp_rx_tag_i(1'b0),
        .pp_rx_err_i(rx_err), .pp_rx_ready_o(rx_ready), .pp_tx_valid_o(tx_valid), .pp_tx_data_o(tx_data),
        .pp_tx_tag_o(tx_tag), .pp_tx_ready_i(tx_ready), .chan_irq_i(1'b0), .chan_reset_o(chan_rst),
        .service_request_n_o(svc_n));
    pfc_port_model i_port (.clk_i(clk), .rst_i(rst), .slow_i(slow), .rx_n_i(rx_n), .err_i(err),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .rx_ready_i(rx_ready), .tx_ready_o(tx_ready),
        .tx_tag_i(tx_tag), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_err_o(rx_err));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
        end
        @(posedge clk) wr <= 1'b0;
    endtask : wreg
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a);
        @(posedge clk) begin
            addr <= a;
            rd <= 1'b1;
        end
        @(posedge clk) rd <= 1'b0;
        #1 got = rdata;
    endtask : rreg
    // bounded wait: a request that never comes fails the check
    task automatic wait_req();
        cycles(1);
        repeat (80) if (dreq_n === 1'b1) cycles(1);
        chk("dma request", 16'h0000, 16'(dreq_n));
    endtask : wait_req
    task automatic dma_ack(input logic [15:0] w);
        @(posedge clk) begin
            dwdata <= w;
            ack <= 1'b1;
        end
        @(posedge clk) ack <= 1'b0;
    endtask : dma_ack
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    // main sequence: table first, then soft reset, dma and interrupt cases
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rreg(PFC_OFF_FIFO_CTRL);
        chk("control reset", 16'h0000, {8'h00, got});
        foreach (rows[i]) begin
            if (rows[i][32]) wreg(rows[i][31:24], rows[i][23:16]);
            rreg(rows[i][15:8]);
            chk("table row", {8'h00, rows[i][7:0]}, {8'h00, got});
        end
        $display("table done");
        wreg(PFC_OFF_SOFT_RST, 8'h01);
        cycles(3);
        chk("channel reset", 16'h0001, 16'(chan_rst));
        rreg(PFC_OFF_FIFO_CTRL);
        chk("control in soft reset", 16'h0000, {8'h00, got});
        rreg(PFC_OFF_SOFT_RST);
        chk("reset register kept", 16'h0001, {8'h00, got});
        wreg(PFC_OFF_SOFT_RST, 8'h00);
        $display("soft reset done");
        slow <= 1'b1;
        wreg(PFC_OFF_FIFO_CTRL, 8'hE0);
        wait_req();
        dma_ack(16'h1234);
        cycles(12);
        wreg(PFC_OFF_FIFO_CTRL, 8'h21);
        wreg(PFC_OFF_DMA_BUFFER_REG, 8'h55);
        wreg(PFC_OFF_DMA_BUFFER_REG, 8'h66);
        cycles(40);
        for (int k = 0; k < 4; k++) chk("tx byte", 16'(txq[k]), 16'(i_port.log_q[k]));
        wreg(PFC_OFF_FIFO_CTRL, 8'hA9);
        wreg(PFC_OFF_DMA_BUFFER_REG, 8'h77);
        wreg(PFC_OFF_DMA_BUFFER_REG, 8'h88);
        cycles(20);
        chk("rle hold", 16'h0004, 16'(i_port.log_cnt_q));
        wreg(PFC_OFF_FIFO_CTRL, 8'h24);
        cycles(5);
        wreg(PFC_OFF_HOLD1, 8'h99);
        rreg(PFC_OFF_FIFO_CTRL);
        chk("tag clear", 16'h0020, {8'h00, got});
        cycles(30);
        for (int k = 4; k < 7; k++) chk("held byte", 16'(txq[k]), 16'(i_port.log_q[k]));
        $display("transmit done");
        slow <= 1'b0;
        wreg(PFC_OFF_THRESH, 8'h02);
        wreg(PFC_OFF_FIFO_CTRL, 8'hC0);
        rx_n <= 8'h08;
        wait_req();
        chk("rx word one", 16'hA2A1, drdata);
        dma_ack(16'h0000);
        wait_req();
        chk("rx word two", 16'hA4A3, drdata);
        $display("receive done");
        wreg(PFC_OFF_FIFO_CTRL, 8'h12);
        @(posedge clk) err <= 1'b1;
        @(posedge clk) err <= 1'b0;
        cycles(5);
        chk("error service", 16'h0000, 16'(svc_n));
        wreg(PFC_OFF_FIFO_CTRL, 8'h02);
        cycles(3);
        chk("masked service", 16'h0001, 16'(svc_n));
        wreg(PFC_OFF_FIFO_CTRL, 8'h12);
        cycles(3);
        chk("re-evaluated service", 16'h0000, 16'(svc_n));
        rreg(PFC_OFF_ERRSTAT);
        chk("error status", 16'h0001, {8'h00, got});
        wreg(PFC_OFF_ERRSTAT, 8'h01);
        cycles(3);
        chk("cleared service", 16'h0001, 16'(svc_n));
        $display("interrupt done");
        conclude();
    end
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule : tb_parallel_fifo_control
